// [include/dds_defines.svh]
// constants for the synthesizer core
`ifndef DDS_DEFINES_SVH
`define DDS_DEFINES_SVH
`define FREQ_W        48
`define TUNE_W        40
`define AMP_W         16
`define OUT_W         14
`define LUT_ADDR_W    24
`define QUAD_MSB      47
`define QUAD_LSB      46
`define BYTES_PER_WD  6
`define SEL_CF_BASE   4'h0
`define SEL_OF_BASE   4'h6
`define SEL_SER_CFG   4'hC
`define SEL_CTRL      4'hD
`define SER_CFG_RST   8'h00
`define CTRL_RST      8'h40
`define CTRL_CF_EN    0
`define CTRL_SER_EN   6
`define SER_CFG_EDGE  0
`define SER_CFG_LEN_L 1
`define SER_CFG_LEN_H 3
`define SER_LEN_MAX   3'h5
`define SER_BYTE_BITS 6'h08
`define WR_DLY        2
`define UPD_DLY       6
`endif

// [include/dds_pkg.sv]
// types for the synthesizer core
package dds_pkg;
  typedef struct packed {
    logic       sel_n;
    logic [3:0] addr;
    logic [7:0] data;
  } host_wr_t;
  typedef enum logic [1:0] {
    SH_IDLE = 2'b00,
    SH_SHIFT = 2'b01,
    SH_DONE = 2'b10
  } ser_state_t;
endpackage

// [src/dds_serial_port.sv]
// serial tuning word receiver
`timescale 1ns/1ps
`include "dds_defines.svh"
module dds_serial_port
  import dds_pkg::*;
(
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_reset,
  input  wire logic                 i_clr,
  input  wire logic                 i_edge_sel,
  input  wire logic [2:0]           i_len,
  input  wire logic                 i_sclk,
  input  wire logic                 i_serial_bit_in,
  input  wire logic                 i_serial_frame_pulse,
  output logic      [`TUNE_W-1:0]   o_word,
  output logic                      o_valid
);
  logic [2:0]         sclk_s_r, sclk_s_nxt;
  logic [1:0]         dat_s_r, dat_s_nxt, syn_s_r, syn_s_nxt;
  logic [`TUNE_W-1:0] sh_r, sh_nxt, word_r, word_nxt;
  logic [5:0]         cnt_r, cnt_nxt;
  logic               valid_r, valid_nxt;
  ser_state_t         st_r, st_nxt;
  logic               edge_hit;
  logic [5:0]         nbits;
  always_comb begin
    sclk_s_nxt = {sclk_s_r[1:0], i_sclk};
    dat_s_nxt  = {dat_s_r[0], i_serial_bit_in};
    syn_s_nxt  = {syn_s_r[0], i_serial_frame_pulse};
    // (R14) selectable shift edge
    edge_hit = i_edge_sel ? (sclk_s_r[2] & ~sclk_s_r[1])
                          : (~sclk_s_r[2] & sclk_s_r[1]);
    nbits = 6'(i_len) * `SER_BYTE_BITS;
    sh_nxt = sh_r;
    cnt_nxt = cnt_r;
    word_nxt = word_r;
    valid_nxt = 1'b0;
    st_nxt = st_r;
    case (st_r)
      SH_IDLE: begin
        if (edge_hit && syn_s_r[1]) begin
          cnt_nxt = 6'h00;
          sh_nxt = '0;
          st_nxt = SH_SHIFT;
        end
      end
      SH_SHIFT: begin
        if (edge_hit) begin
          sh_nxt = {sh_r[`TUNE_W-2:0], dat_s_r[1]};
          cnt_nxt = cnt_r + 6'h01;
          if (cnt_r + 6'h01 == nbits) st_nxt = SH_DONE;
        end
      end
      SH_DONE: begin
        // (R02) left align into tuning word
        word_nxt = sh_r << (6'(`TUNE_W) - nbits);
        valid_nxt = 1'b1;
        st_nxt = SH_IDLE;
      end
      default: st_nxt = SH_IDLE;
    endcase
    if (i_clr) begin
      word_nxt = '0;
      st_nxt = SH_IDLE;
    end
  end
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      sclk_s_r <= 3'h0;
      dat_s_r <= 2'h0;
      syn_s_r <= 2'h0;
      sh_r <= '0;
      word_r <= '0;
      cnt_r <= 6'h00;
      valid_r <= 1'b0;
      st_r <= SH_IDLE;
    end else begin
      sclk_s_r <= sclk_s_nxt;
      dat_s_r <= dat_s_nxt;
      syn_s_r <= syn_s_nxt;
      sh_r <= sh_nxt;
      word_r <= word_nxt;
      cnt_r <= cnt_nxt;
      valid_r <= valid_nxt;
      st_r <= st_nxt;
    end
  end
  assign o_word = word_r;
  assign o_valid = valid_r;
endmodule

// [src/dds_sine_map.sv]
// phase to amplitude map
`timescale 1ns/1ps
`include "dds_defines.svh"
module dds_sine_map (
  input  wire logic                   i_ref_clk,
  input  wire logic [`LUT_ADDR_W-1:0] i_phase,
  output logic      [`OUT_W-1:0]      o_amp
);
  logic [`AMP_W-1:0] amp_r, amp_nxt;
  logic [`OUT_W-1:0] out_r, out_nxt;
  logic [`AMP_W:0]   rnd;
  real               ang;
  always_comb begin
    // (R17) 24 phase bits to 16-bit sine
    ang = 6.283185307179586 * real'(i_phase) / 16777216.0;
    amp_nxt = `AMP_W'($rtoi(32767.0 * $sin(ang) + 32768.0));
    // (R17) round to converter width
    rnd = {1'b0, amp_r} + 17'h00002;
    out_nxt = rnd[`AMP_W] ? {`OUT_W{1'b1}} : rnd[`AMP_W-1:2];
  end
  always_ff @(posedge i_ref_clk) begin
    amp_r <= amp_nxt;
    out_r <= out_nxt;
  end
  assign o_amp = out_r;
endmodule

// [src/dds_nco_core.sv]
// synthesizer core: host registers, accumulator and output
`timescale 1ns/1ps
`include "dds_defines.svh"
// How it works
// (R01) center and offset words, host written
// (R02) serial tuning word up to 40 bits
// (R03) quadrant select shifts phase by 90s
// (R04) gate high adds offset, low zero
// (R05) gating leaves stored offset unchanged
// (R06) strobe rise with select stores byte
// (R07) host holds select low to write
// (R08) 4-bit select picks destination register
// (R09) update copies masters to active together
// (R10) update ignores gate and quadrant inputs
// (R11) accumulator and sample advance each clock
// (R12) reset restores defaults, clears accumulator
// (R13) update held low during reset
// (R14) serial edge selectable, clock asynchronous
// (R15) 14-bit sample every clock
// (R16) three terms summed modulo 2^48
// (R17) top 24 bits to rounded sine
// (R18) latency eleven or fourteen clocks
// (R19) host writes at most every two clocks
// (R20) quadrant added to top phase bits
module dds_nco_core
  import dds_pkg::*;
(
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_reset,
  input  wire logic                 i_reset_n,
  input  wire dds_pkg::host_wr_t    i_host,
  input  wire logic                 i_load_strobe,
  input  wire logic                 i_update_n,
  input  wire logic [1:0]           i_quadrant_select,
  input  wire logic                 i_offset_term_gate,
  input  wire logic                 i_sclk,
  input  wire logic                 i_serial_bit_in,
  input  wire logic                 i_serial_frame_pulse,
  output logic      [`OUT_W-1:0]    o_amplitude,
  output logic      [`FREQ_W-1:0]   o_phase
);
  host_wr_t           host_s1_r, host_s2_r;
  logic [2:0]         stb_s_r;
  logic [1:0]         upd_s_r, rstn_s_r, gate_s_r;
  logic [3:0]         quad_s_r;
  logic [7:0]         cf_m_r [`BYTES_PER_WD];
  logic [7:0]         of_m_r [`BYTES_PER_WD];
  logic [7:0]         cf_m_nxt [`BYTES_PER_WD];
  logic [7:0]         of_m_nxt [`BYTES_PER_WD];
  logic [7:0]         scfg_m_r, scfg_m_nxt, ctrl_m_r, ctrl_m_nxt;
  logic [`FREQ_W-1:0] cf_a_r, cf_a_nxt, of_a_r, of_a_nxt;
  logic [7:0]         scfg_a_r, scfg_a_nxt, ctrl_a_r, ctrl_a_nxt;
  logic [`FREQ_W-1:0] cf_m_flat, of_m_flat;
  logic [`FREQ_W-1:0] inc_r, inc_nxt, acc_r, acc_nxt;
  logic [`FREQ_W-1:0] sf_term, of_term, cf_term;
  logic [`LUT_ADDR_W-1:0] lut_phase_r, lut_phase_nxt;
  logic               wr_hit, upd_act, rst_act, wr_go, upd_go;
  logic [`WR_DLY-1:0] wr_dly_r, wr_dly_nxt;
  logic [`UPD_DLY-1:0] upd_dly_r, upd_dly_nxt;
  host_wr_t           hw_dly_r [`WR_DLY];
  host_wr_t           hw_dly_nxt [`WR_DLY];
  host_wr_t           wr_byte;
  logic [`TUNE_W-1:0] ser_word;
  logic               ser_valid;
  // pin synchronisers
  always_ff @(posedge i_ref_clk) begin
    host_s1_r <= i_host;
    host_s2_r <= host_s1_r;
    stb_s_r <= {stb_s_r[1:0], i_load_strobe};
    upd_s_r <= {upd_s_r[0], i_update_n};
    rstn_s_r <= {rstn_s_r[0], i_reset_n};
    gate_s_r <= {gate_s_r[0], i_offset_term_gate};
    quad_s_r <= {quad_s_r[1:0], i_quadrant_select};
  end
  always_comb begin
    // (R06) store byte on strobe rise
    // (R07) writes only while select is low
    wr_hit = ~stb_s_r[2] & stb_s_r[1] & ~host_s2_r.sel_n;
    upd_act = ~upd_s_r[1];
    // (R12) reset needs update low too
    rst_act = ~rstn_s_r[1] & upd_act;
    // (R18) pad write and update paths
    wr_dly_nxt = {wr_dly_r[`WR_DLY-2:0], wr_hit};
    upd_dly_nxt = {upd_dly_r[`UPD_DLY-2:0], upd_act};
    hw_dly_nxt[0] = host_s2_r;
    for (int i = 1; i < `WR_DLY; i++) begin
      hw_dly_nxt[i] = hw_dly_r[i-1];
    end
    wr_go = wr_dly_r[`WR_DLY-1];
    upd_go = upd_dly_r[`UPD_DLY-1];
    wr_byte = hw_dly_r[`WR_DLY-1];
    for (int i = 0; i < `BYTES_PER_WD; i++) begin
      cf_m_nxt[i] = cf_m_r[i];
      of_m_nxt[i] = of_m_r[i];
    end
    scfg_m_nxt = scfg_m_r;
    ctrl_m_nxt = ctrl_m_r;
    if (wr_go) begin
      // (R08) decode 4-bit register select
      if (wr_byte.addr < `SEL_OF_BASE) begin
        // (R01) center word byte
        cf_m_nxt[3'(wr_byte.addr)] = wr_byte.data;
      end else if (wr_byte.addr < `SEL_SER_CFG) begin
        // (R01) offset word byte
        of_m_nxt[3'(wr_byte.addr - `SEL_OF_BASE)] = wr_byte.data;
      end else if (wr_byte.addr == `SEL_SER_CFG) begin
        scfg_m_nxt = wr_byte.data;
      end else if (wr_byte.addr == `SEL_CTRL) begin
        ctrl_m_nxt = wr_byte.data;
      end
    end
    for (int i = 0; i < `BYTES_PER_WD; i++) begin
      cf_m_flat[i*8 +: 8] = cf_m_r[i];
      of_m_flat[i*8 +: 8] = of_m_r[i];
    end
    cf_a_nxt = cf_a_r;
    of_a_nxt = of_a_r;
    scfg_a_nxt = scfg_a_r;
    ctrl_a_nxt = ctrl_a_r;
    // (R09) copy all masters at once
    if (upd_go) begin
      cf_a_nxt = cf_m_flat;
      of_a_nxt = of_m_flat;
      scfg_a_nxt = scfg_m_r;
      ctrl_a_nxt = ctrl_m_r;
    end
    // (R04) gate offset term into sum
    // (R05) stored offset is left untouched
    // (R10) gate acts without update
    of_term = gate_s_r[1] ? of_a_r : '0;
    cf_term = ctrl_a_r[`CTRL_CF_EN] ? cf_a_r : '0;
    sf_term = ctrl_a_r[`CTRL_SER_EN] ? {ser_word, 8'h00} : '0;
    // (R16) modulo 2^48 frequency sum
    inc_nxt = cf_term + of_term + sf_term;
    // (R11) accumulate every clock
    acc_nxt = acc_r + inc_r;
    // (R03) quadrant shift
    // (R20) added to top two phase bits
    lut_phase_nxt = acc_r[`FREQ_W-1 -: `LUT_ADDR_W]
                  + {quad_s_r[3:2], {(`LUT_ADDR_W-2){1'b0}}};
  end
  always_ff @(posedge i_ref_clk) begin
    // (R12) defaults and cleared feedback
    if (i_reset || rst_act) begin
      for (int i = 0; i < `BYTES_PER_WD; i++) begin
        cf_m_r[i] <= 8'h00;
        of_m_r[i] <= 8'h00;
      end
      scfg_m_r <= `SER_CFG_RST;
      ctrl_m_r <= `CTRL_RST;
      cf_a_r <= '0;
      of_a_r <= '0;
      scfg_a_r <= `SER_CFG_RST;
      ctrl_a_r <= `CTRL_RST;
      inc_r <= '0;
      acc_r <= '0;
      lut_phase_r <= '0;
      wr_dly_r <= '0;
      upd_dly_r <= '0;
    end else begin
      cf_m_r <= cf_m_nxt;
      of_m_r <= of_m_nxt;
      scfg_m_r <= scfg_m_nxt;
      ctrl_m_r <= ctrl_m_nxt;
      cf_a_r <= cf_a_nxt;
      of_a_r <= of_a_nxt;
      scfg_a_r <= scfg_a_nxt;
      ctrl_a_r <= ctrl_a_nxt;
      inc_r <= inc_nxt;
      acc_r <= acc_nxt;
      lut_phase_r <= lut_phase_nxt;
      wr_dly_r <= wr_dly_nxt;
      upd_dly_r <= upd_dly_nxt;
      hw_dly_r <= hw_dly_nxt;
    end
  end
  // (R02) serial tuning word receiver
  // (R14) edge chosen by serial config
  dds_serial_port u_ser (
    .i_ref_clk            (i_ref_clk),
    .i_reset              (i_reset),
    .i_clr                (rst_act),
    .i_edge_sel           (scfg_a_r[`SER_CFG_EDGE]),
    .i_len                (scfg_a_r[`SER_CFG_LEN_H:`SER_CFG_LEN_L] == 3'h0 ?
                           `SER_LEN_MAX :
                           scfg_a_r[`SER_CFG_LEN_H:`SER_CFG_LEN_L]),
    .i_sclk               (i_sclk),
    .i_serial_bit_in      (i_serial_bit_in),
    .i_serial_frame_pulse (i_serial_frame_pulse),
    .o_word               (ser_word),
    .o_valid              (ser_valid)
  );
  // (R15) 14-bit sample each clock
  // (R17) rounded sine of top bits
  dds_sine_map u_sine (
    .i_ref_clk (i_ref_clk),
    .i_phase   (lut_phase_r),
    .o_amp     (o_amplitude)
  );
  assign o_phase = acc_r;
endmodule

// [sim/dds_nco_core_checker.sv]
// assertions on the synthesizer core ports
`timescale 1ns/1ps
module dds_nco_core_checker (
  input wire logic              i_ref_clk,
  input wire logic              i_reset,
  input wire logic              i_reset_n,
  input wire dds_pkg::host_wr_t i_host,
  input wire logic              i_load_strobe,
  input wire logic              i_update_n,
  input wire logic [1:0]        i_quadrant_select,
  input wire logic              i_offset_term_gate,
  input wire logic              i_sclk,
  input wire logic              i_serial_bit_in,
  input wire logic              i_serial_frame_pulse,
  input wire logic [13:0]       o_amplitude,
  input wire logic [47:0]       o_phase
);
  import dds_pkg::*;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  logic [3:0] pin_r, pin_nxt;
  logic [4:0] q_r, q_nxt;
  // cycles since anything but quadrant could move the step
  always_comb begin
    pin_nxt = {i_sclk, i_offset_term_gate, i_update_n, i_reset_n};
    q_nxt = (q_r == 5'h1F) ? q_r : q_r + 5'h01;
    if (i_reset || pin_nxt != pin_r ||
        (i_load_strobe && !i_host.sel_n && !i_update_n)) begin
      q_nxt = 5'h00;
    end
  end
  always_ff @(posedge i_ref_clk) begin
    pin_r <= pin_nxt;
    q_r   <= q_nxt;
  end
  sequence s_pin;
    !i_reset_n && !i_update_n && i_quadrant_select == 2'b00;
  endsequence
  property p_rst_phase;
    $fell(i_reset) |-> o_phase == 48'h0;
  endproperty
  a_rst_phase: assert property (p_rst_phase)
    else $error("phase not cleared by reset");
  property p_rst_idle;
    $fell(i_reset) |=> (o_phase == 48'h0)[*3];
  endproperty
  a_rst_idle: assert property (p_rst_idle)
    else $error("phase moved with default registers");
  property p_rst_amp;
    $fell(i_reset) && $past(i_reset, 4) && i_quadrant_select == 2'b00
      |-> o_amplitude == 14'h2000;
  endproperty
  a_rst_amp: assert property (p_rst_amp)
    else $error("amplitude not midscale after reset");
  property p_pin_rst;
    s_pin[*8] |-> o_phase == 48'h0;
  endproperty
  a_pin_rst: assert property (p_pin_rst)
    else $error("pin reset left phase nonzero");
  property p_pin_amp;
    s_pin[*8] ##1 s_pin[*4] |-> o_amplitude == 14'h2000;
  endproperty
  a_pin_amp: assert property (p_pin_amp)
    else $error("pin reset left amplitude off midscale");
  property p_inc;
    q_r >= 5'h18 |->
      48'(o_phase - $past(o_phase)) == 48'($past(o_phase) - $past(o_phase, 2));
  endproperty
  a_inc: assert property (p_inc)
    else $error("phase step changed without cause");
  property p_amp_hold;
    ($stable(o_phase) && $stable(i_quadrant_select))[*8]
      |-> $stable(o_amplitude);
  endproperty
  a_amp_hold: assert property (p_amp_hold)
    else $error("amplitude moved with phase still");
  property p_quad_move;
    $changed(i_quadrant_select) && $stable(o_phase)
      |-> ##[1:12] $changed(o_amplitude);
  endproperty
  a_quad_move: assert property (p_quad_move)
    else $error("quadrant change ignored");
endmodule
bind dds_nco_core dds_nco_core_checker chk (
  .i_ref_clk, .i_reset, .i_reset_n, .i_host, .i_load_strobe,
  .i_update_n, .i_quadrant_select, .i_offset_term_gate, .i_sclk,
  .i_serial_bit_in, .i_serial_frame_pulse, .o_amplitude, .o_phase
);

// [sim/dds_host_model.sv]
// host processor writing control bytes
`timescale 1ns/1ps
module dds_host_model (
  input  wire logic         i_ref_clk,
  output dds_pkg::host_wr_t o_host,
  output logic              o_load_strobe
);
  import dds_pkg::*;
  initial begin
    o_host = '{1'b1, 4'h0, 8'h00};
    o_load_strobe = 1'b0;
  end
  task automatic wr(input logic s, input logic [3:0] a, input logic [7:0] d);
    @(negedge i_ref_clk);
    o_host = '{s, a, d};
    repeat (3) @(negedge i_ref_clk);
    o_load_strobe = 1'b1;
    repeat (3) @(negedge i_ref_clk);
    o_load_strobe = 1'b0;
    repeat (3) @(negedge i_ref_clk);
    o_host = '{1'b1, ~a, ~d};
  endtask
endmodule

// [sim/dds_nco_core_bench.sv]
// self-checking bench for the synthesizer core
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_total++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
module dds_nco_core_bench;
  import dds_pkg::*;
  typedef struct packed {
    logic [47:0] cf;
    logic [47:0] of;
    logic        gate;
    logic [47:0] inc;
  } row_t;
  logic        clk, rst, rst_n, strobe, upd_n, gate, sclk, sbit, sync;
  logic [1:0]  quad;
  logic [13:0] amp;
  logic [47:0] ph, d, base;
  logic [13:0] lo [4];
  logic [13:0] hi [4];
  host_wr_t    host;
  row_t        rows [5];
  int          err_total, n_tests, cyc;
  dds_host_model host_m (.i_ref_clk(clk), .o_host(host),
    .o_load_strobe(strobe));
  dds_nco_core dut (.i_ref_clk(clk), .i_reset(rst), .i_reset_n(rst_n),
    .i_host(host), .i_load_strobe(strobe), .i_update_n(upd_n),
    .i_quadrant_select(quad), .i_offset_term_gate(gate), .i_sclk(sclk),
    .i_serial_bit_in(sbit), .i_serial_frame_pulse(sync),
    .o_amplitude(amp), .o_phase(ph));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 10000) begin
      err_total++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("tests %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic meas();
    repeat (40) @(negedge clk);
    base = ph;
    @(negedge clk);
    d = ph - base;
  endtask
  task automatic ld(input logic [47:0] c, input logic [47:0] o);
    for (int i = 0; i < 6; i++) begin
      host_m.wr(1'b0, 4'(i), c[8*i+:8]);
      host_m.wr(1'b0, 4'(i + 6), o[8*i+:8]);
    end
  endtask
  task automatic ser(input logic [39:0] w, input int n, input logic f);
    sclk = f;
    for (int k = -1; k < n; k++) begin
      sync = (k < 0);
      sbit = (k < 0) ? 1'b0 : w[39-k];
      #40 sclk = ~f;
      #40 sclk = f;
    end
    sync = 1'b0;
    sbit = ~sbit;
  endtask
  initial begin
    rows = '{'{48'h1, 48'h10, 1'b0, 48'h1},
             '{48'h1, 48'h10, 1'b1, 48'h11},
             '{48'h8000_0000_0000, 48'h8000_0000_0001, 1'b1, 48'h1},
             '{48'hFFFF_FFFF_FFFF, 48'h0, 1'b0, 48'hFFFF_FFFF_FFFF},
             '{48'h0102_0304_0506, 48'h1000_0000_0000, 1'b1,
               48'h1102_0304_0506}};
    lo = '{14'h2000, 14'h3F00, 14'h1F00, 14'h0000};
    hi = '{14'h2000, 14'h3FFF, 14'h2100, 14'h0100};
    rst = 1'b1;
    rst_n = 1'b1;
    upd_n = 1'b0;
    quad = 2'b00;
    gate = 1'b0;
    sclk = 1'b0;
    sbit = 1'b0;
    sync = 1'b0;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    host_m.wr(1'b0, 4'hD, 8'h41);
    foreach (rows[i]) begin
      gate = rows[i].gate;
      ld(rows[i].cf, rows[i].of);
      meas();
      `CHK(d, rows[i].inc)
    end
    gate = 1'b0;
    meas();
    `CHK(d, 48'h0102_0304_0506)
    gate = 1'b1;
    meas();
    `CHK(d, 48'h1102_0304_0506)
    host_m.wr(1'b1, 4'h0, 8'hFF);
    meas();
    `CHK(d, 48'h1102_0304_0506)
    upd_n = 1'b1;
    repeat (8) @(negedge clk);
    host_m.wr(1'b0, 4'h0, 8'h00);
    host_m.wr(1'b0, 4'h6, 8'h01);
    gate = 1'b0;
    meas();
    `CHK(d, 48'h0102_0304_0506)
    upd_n = 1'b0;
    gate = 1'b1;
    meas();
    `CHK(d, 48'h1102_0304_0501)
    ser(40'h00_0000_0001, 40, 1'b0);
    meas();
    `CHK(d, 48'h1102_0304_0601)
    host_m.wr(1'b0, 4'hC, 8'h03);
    ser(40'h02_0000_0000, 8, 1'b1);
    meas();
    `CHK(d, 48'h1302_0304_0501)
    upd_n = 1'b1;
    rst_n = 1'b0;
    meas();
    `CHK(d, 48'h1302_0304_0501)
    upd_n = 1'b0;
    repeat (16) @(negedge clk);
    `CHK(ph, 48'h0)
    rst_n = 1'b1;
    for (int q = 1; q < 5; q++) begin
      quad = 2'(q);
      repeat (20) @(negedge clk);
      `CHK(amp >= lo[quad] && amp <= hi[quad], 1'b1)
      `CHK(ph, 48'h0)
    end
    host_m.wr(1'b0, 4'hD, 8'h41);
    host_m.wr(1'b0, 4'h5, 8'h40);
    repeat (4) @(negedge clk);
    `CHK(amp, 14'h2000)
    @(negedge clk);
    `CHK(amp, 14'h3FFF)
    rst_n = 1'b0;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    host_m.wr(1'b0, 4'hD, 8'h41);
    upd_n = 1'b1;
    repeat (8) @(negedge clk);
    host_m.wr(1'b0, 4'h5, 8'h40);
    upd_n = 1'b0;
    repeat (13) @(negedge clk);
    `CHK(amp, 14'h2000)
    @(negedge clk);
    `CHK(amp, 14'h3FFF)
    finish_test();
  end
endmodule
